// ==== bench/rsc_board_model.sv ====
// Board model: supply monitor, brown-out detector, reset pin, clock-ready.
// Assumes its tasks are called just after a rising edge of clk.
module rsc_board_model (
   input logic clk,
   output logic supply_good,
   output logic bod_below,
   output logic rst_pin_n,
   output logic clk_stable
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      supply_good = 1'b1;
      bod_below = 1'b0;
      rst_pin_n = 1'b1;
      clk_stable = 1'b1;
   end
   task automatic drive(input logic sg, input logic bb, input logic cs, input logic pn);
      supply_good <= sg;
      bod_below <= bb;
      clk_stable <= cs;
      rst_pin_n <= pn;
   endtask
   // Pin low for exactly n edges; under 24 is the glitch case
   task automatic pin_low(input int n);
      rst_pin_n <= 1'b0;
      repeat (n) @(posedge clk);
      rst_pin_n <= 1'b1;
   endtask
endmodule

// ==== bench/rsc_props.sv ====
// Port-level assertions for the reset source controller.
// Assumes one clock domain whose asynchronous reset is nrst.
module rsc_props (
   input logic clk,
   input logic nrst,
   input logic wb_cyc_i,
   input logic wb_stb_i,
   input logic wb_ack_o,
   input logic [31:0] wb_dat_o,
   input logic supply_good,
   input logic bod_below,
   input logic rst_pin_n,
   input logic wdt_reset_req,
   input logic sw_reset_req,
   input logic power_down,
   input logic clk_stable,
   input logic clk_wake,
   input logic sys_rst_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pin low count; holds while the clock is not yet stable
   logic [4:0] low_q;
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
         low_q <= 5'h00;
      else if (rst_pin_n)
         low_q <= 5'h00;
      else if (clk_stable && low_q != 5'h18)
         low_q <= low_q + 5'h01;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   chk_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   chk_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   chk_rd_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("read upper bits set");
   chk_supply_low_rst: assert property (!supply_good |=> !sys_rst_n)
      else $error("no reset on low supply");
   chk_other_src_rst: assert property (wdt_reset_req || sw_reset_req |=> !sys_rst_n)
      else $error("no reset on request");
   chk_pin_long_rst: assert property (low_q == 5'h18 && !rst_pin_n |=> !sys_rst_n)
      else $error("no reset on long pin low");
   chk_quiet_release: assert property (
      (supply_good && !bod_below && !wdt_reset_req && !sw_reset_req && low_q != 5'h18) [*3]
      |=> sys_rst_n)
      else $error("reset without source");
   chk_wake_path: assert property (clk_wake == (power_down && !rst_pin_n))
      else $error("wake wrong");
endmodule

bind rsc_top rsc_props rsc_props_inst (
   .clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .supply_good(supply_good),
   .bod_below(bod_below), .rst_pin_n(rst_pin_n), .wdt_reset_req(wdt_reset_req),
   .sw_reset_req(sw_reset_req), .power_down(power_down), .clk_stable(clk_stable),
   .clk_wake(clk_wake), .sys_rst_n(sys_rst_n));

// ==== bench/tb_top.sv ====
// Self-checking bench for the reset source controller.
// Assumes the board model on the supply and pin side, 40 MHz clock.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, wdt = 1'b0, sw = 1'b0, pd = 1'b0;
   logic saw = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [3:0] sel = 4'h1;
   logic [31:0] wd = 32'h0;
   logic [7:0] v;
   wire [31:0] rd;
   wire [2:0] lvl;
   wire ack, sg, bb, pn, cs, wake, srst_n, bde, irq;
   int num_errors = 0;
   int n_checks = 0;
   int cnt = 0;

   rsc_board_model brd (.clk(clk), .supply_good(sg), .bod_below(bb), .rst_pin_n(pn),
      .clk_stable(cs));
   rsc_top rsc_top_inst (
      .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
      .supply_good(sg), .bod_below(bb), .rst_pin_n(pn), .wdt_reset_req(wdt),
      .sw_reset_req(sw), .power_down(pd), .clk_stable(cs), .clk_wake(wake),
      .sys_rst_n(srst_n), .brownout_detect_enable(bde), .brownout_level_select(lvl),
      .irq(irq));

   initial forever #12.5 clk = ~clk;

   // Records any internal reset; the hang limit is far above the run length
   always @(posedge clk) begin
      cnt <= cnt + 1;
      if (srst_n === 1'b0)
         saw <= 1'b1;
      if (cnt == 2000) begin
         num_errors++;
         tally_and_finish;
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] e);
      n_checks++;
      if (seen !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", s, e, seen);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wd <= {24'h000000, d};
      do
         @(posedge clk);
      while (ack !== 1'b1);
      v = rd[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rc(input logic [7:0] idx, input logic [7:0] e);
      wb(1'b0, idx, 8'h00);
      chk($sformatf("reg %h", idx), v, e);
   endtask
   task automatic bit_is(input string s, input logic x, input logic e);
      chk(s, {7'h00, x}, {7'h00, e});
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      tick(16);
      nrst <= 1'b1;
      tick(1);
      rc(8'h87, 8'h10);
      rc(8'ha2, 8'h00);
      rc(8'ha3, 8'h84);
      rc(8'h10, 8'h00);
      wb(1'b1, 8'h87, 8'hef);
      rc(8'h87, 8'hcf);
      saw = 1'b0;
      wdt <= 1'b1;
      tick(1);
      wdt <= 1'b0;
      sw <= 1'b1;
      tick(1);
      sw <= 1'b0;
      tick(3);
      bit_is("reset", saw, 1'b1);
      rc(8'h87, 8'h00);
      rc(8'ha2, 8'h80);
      wb(1'b1, 8'ha2, 8'h00);
      wb(1'b1, 8'ha3, 8'hd6);
      rc(8'ha3, 8'hd6);
      chk("level", {5'h00, lvl}, 8'h05);
      bit_is("detect", bde, 1'b1);
      wb(1'b1, 8'ha3, 8'h84);
      rc(8'ha3, 8'h84);
      $display("warm reset test done");
      saw = 1'b0;
      brd.drive(1'b1, 1'b1, 1'b1, 1'b1);
      tick(4);
      brd.drive(1'b1, 1'b0, 1'b1, 1'b1);
      tick(4);
      bit_is("reset", saw, 1'b1);
      rc(8'ha3, 8'h86);
      rc(8'ha2, 8'h00);
      $display("brown-out test done");
      wb(1'b1, 8'hb1, 8'h02);
      saw = 1'b0;
      brd.pin_low(23);
      tick(3);
      bit_is("reset", saw, 1'b0);
      bit_is("irq", irq, 1'b1);
      rc(8'hb0, 8'h02);
      rc(8'ha2, 8'h00);
      wb(1'b1, 8'hb0, 8'h02);
      bit_is("irq", irq, 1'b0);
      wb(1'b1, 8'hb1, 8'h00);
      brd.pin_low(5);
      tick(3);
      bit_is("irq", irq, 1'b0);
      wb(1'b1, 8'hb1, 8'h02);
      bit_is("irq", irq, 1'b1);
      wb(1'b1, 8'hb0, 8'h02);
      $display("glitch test done");
      saw = 1'b0;
      brd.pin_low(24);
      tick(3);
      bit_is("reset", saw, 1'b1);
      rc(8'ha2, 8'h40);
      rc(8'ha3, 8'h86);
      rc(8'h87, 8'h00);
      wb(1'b1, 8'ha2, 8'h00);
      rc(8'ha2, 8'h00);
      saw = 1'b0;
      pd <= 1'b1;
      brd.drive(1'b1, 1'b0, 1'b0, 1'b0);
      tick(2);
      bit_is("wake", wake, 1'b1);
      tick(30);
      bit_is("reset", saw, 1'b0);
      pd <= 1'b0;
      brd.drive(1'b1, 1'b0, 1'b1, 1'b0);
      tick(27);
      bit_is("reset", saw, 1'b1);
      brd.drive(1'b1, 1'b0, 1'b1, 1'b1);
      tick(3);
      rc(8'ha2, 8'h40);
      $display("pin reset test done");
      saw = 1'b0;
      brd.drive(1'b0, 1'b0, 1'b1, 1'b1);
      tick(3);
      brd.drive(1'b1, 1'b0, 1'b1, 1'b1);
      tick(3);
      bit_is("reset", saw, 1'b1);
      rc(8'h87, 8'h10);
      rc(8'ha2, 8'h00);
      rc(8'ha3, 8'h84);
      // A write without the low byte lane must leave the flag alone
      sel <= 4'h0;
      wb(1'b1, 8'h87, 8'h00);
      sel <= 4'h1;
      rc(8'h87, 8'h10);
      $display("cold reset test done");
      tally_and_finish;
   end
endmodule

// ==== common/rsc_consts.vh ====
// Constants of the reset source controller: register indices, field positions,
// reset values and the pin qualification count.
// Assumes a byte-wide register file behind a 32-bit classic Wishbone slave.
//
// Function
// - Power-on, brown-out, pin, watchdog and software requests each reset the system.
// - Every reset returns the registers to defaults; only cause flags depend on source.
// - Supply below threshold holds the core in reset; release starts fetch at zero.
// - Cold-start flag, power control bit 4, is set by a power-on reset.
// - Cold-start flag keeps its value through every other kind of reset.
// - Software may write the cold-start flag, normally to clear it.
// - Detector below level with brown-out reset enable bit 2 set resets the system.
// - Brown-out reset flag, bit 1 of brown-out control, is set by such a reset.
// - Brown-out reset flag changes only on power-on or brown-out reset, or by writing.
// - Software may both set and clear the brown-out reset flag.
// - The pin must stay low at least 24 clocks; that is a valid request.
// - The pin request resets the system synchronously to the system clock.
// - Reset lasts while the pin is low and ends once it returns high.
// - Pin low in power-down restarts the clock; reset waits for stable clock.
// - Pin reset flag, bit 6 of auxiliary register 1, is set by a pin reset.
// - Pin reset flag changes only on power-on or pin reset, or by writing.
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RSC_IDX_PWR 8'h87
`define RSC_IDX_AUX 8'ha2
`define RSC_IDX_BOD 8'ha3
`define RSC_IDX_IST 8'hb0
`define RSC_IDX_IMSK 8'hb1

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RSC_PWR_COLD 4
`define RSC_BOD_DETEN 7
`define RSC_BOD_LVL_HI 6
`define RSC_BOD_LVL_LO 4
`define RSC_BOD_DETF 3
`define RSC_BOD_RSTEN 2
`define RSC_BOD_RFLAG 1
`define RSC_BOD_STAT 0
`define RSC_AUX_SOFT 7
`define RSC_AUX_PIN 6
`define RSC_IRQ_BOD 0
`define RSC_IRQ_GLITCH 1
`define RSC_IRQ_W 2

// ----------------------------------------------------------------
// Plain storage masks and reset values
// ----------------------------------------------------------------
`define RSC_PWR_STORE 8'hcf
`define RSC_AUX_STORE 8'h3d
`define RSC_BOD_STORE 8'hf4
`define RSC_PWR_RST 8'h00
`define RSC_AUX_RST 8'h00
`define RSC_BOD_RST 8'h84

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RSC_PIN_MIN_CYC 5'd24

`endif

// ==== rtl/rsc_event_reg.v ====
// Sticky event status with write-one-to-clear, a mask and a level interrupt.
// Assumes write strobes are single-cycle and the clear input is synchronous.
`include "rsc_consts.vh"

module rsc_event_reg (
   input wire clk,
   input wire nrst,
   input wire clr,
   input wire [`RSC_IRQ_W-1:0] ev,
   input wire wr_st,
   input wire wr_msk,
   input wire [`RSC_IRQ_W-1:0] wdata,
   output reg [`RSC_IRQ_W-1:0] st_q,
   output reg [`RSC_IRQ_W-1:0] msk_q,
   output wire irq
);

   reg [`RSC_IRQ_W-1:0] st_d;

   always @* begin
      st_d = st_q;
      if (wr_st) begin
         st_d = st_d & ~wdata;
      end
      // A new event in the clearing cycle survives
      st_d = st_d | ev;
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= {`RSC_IRQ_W{1'b0}};
         msk_q <= {`RSC_IRQ_W{1'b0}};
      end else if (clr) begin
         st_q <= {`RSC_IRQ_W{1'b0}};
         msk_q <= {`RSC_IRQ_W{1'b0}};
      end else begin
         st_q <= st_d;
         if (wr_msk) begin
            msk_q <= wdata;
         end
      end
   end

   assign irq = |(st_q & msk_q);

endmodule

// ==== rtl/rsc_pin_filter.v ====
// Qualifies the external reset pin: a request only after a long enough low.
// Assumes the pin is already synchronous to clk.
`include "rsc_consts.vh"

module rsc_pin_filter (
   input wire clk,
   input wire nrst,
   input wire pin_n,
   input wire count_en,
   output wire rst_req,
   output reg glitch
);

   reg [4:0] cnt_q;

   // ----------------------------------------------------------------
   // Low-time counter
   // ----------------------------------------------------------------
   // Counting stops while the clock is not yet stable after a wake-up
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 5'h00;
         glitch <= 1'b0;
      end else begin
         glitch <= 1'b0;
         if (pin_n) begin
            // Short low pulse dropped, only reported as an event
            if (cnt_q != 5'h00 && cnt_q != `RSC_PIN_MIN_CYC) begin
               glitch <= 1'b1;
            end
            cnt_q <= 5'h00;
         end else if (count_en && cnt_q != `RSC_PIN_MIN_CYC) begin
            cnt_q <= cnt_q + 5'h01;
         end
      end
   end

   // Request stands while the pin stays low after qualification
   assign rst_req = (cnt_q == `RSC_PIN_MIN_CYC);

endmodule

// ==== rtl/rsc_top.v ====
// Reset source controller: combines the reset sources into one synchronous
// system reset, records the cause flags and exposes them over Wishbone.
// Assumes nrst is the raw power-on reset and all other inputs are synchronous.
//
// The Wishbone interface to the registers was chosen for this implementation.
`include "rsc_consts.vh"

module rsc_top (
   input wire clk,
   input wire nrst,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [9:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire supply_good,
   input wire bod_below,
   input wire rst_pin_n,
   input wire wdt_reset_req,
   input wire sw_reset_req,
   input wire power_down,
   input wire clk_stable,
   output wire clk_wake,
   output wire sys_rst_n,
   output wire brownout_detect_enable,
   output wire [2:0] brownout_level_select,
   output wire irq
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   reg sys_rst_q;
   reg cold_start_flag_q;
   reg brownout_reset_flag_q;
   reg pin_reset_flag_q;
   reg soft_reset_flag_q;
   reg brownout_detect_flag_q;
   reg [7:0] pwr_q;
   reg [7:0] aux_q;
   reg [7:0] bod_q;
   reg [7:0] rd_d;
   wire pin_req;
   wire pin_glitch;
   wire bod_req;
   wire brownout_status;
   wire rst_req;
   wire bus_req;
   wire wr_cyc;
   wire [7:0] idx;
   wire wr_pwr;
   wire wr_aux;
   wire wr_bod;
   wire wr_ist;
   wire wr_imsk;
   wire [7:0] wd;
   wire [`RSC_IRQ_W-1:0] ist;
   wire [`RSC_IRQ_W-1:0] imsk;
   wire [`RSC_IRQ_W-1:0] events;
   reg bod_below_q;

   // ----------------------------------------------------------------
   // Reset sources
   // ----------------------------------------------------------------
   // The stopped clock can only be restarted combinationally from the pin
   assign clk_wake = power_down & ~rst_pin_n;

   rsc_pin_filter u_pin (
      .clk(clk),
      .nrst(nrst),
      .pin_n(rst_pin_n),
      .count_en(clk_stable),
      .rst_req(pin_req),
      .glitch(pin_glitch)
   );

   assign brownout_detect_enable = bod_q[`RSC_BOD_DETEN];
   assign brownout_level_select = bod_q[`RSC_BOD_LVL_HI:`RSC_BOD_LVL_LO];
   assign brownout_status = bod_below & bod_q[`RSC_BOD_DETEN];
   assign bod_req = brownout_status & bod_q[`RSC_BOD_RSTEN];

   assign rst_req = ~supply_good | bod_req | pin_req | wdt_reset_req | sw_reset_req;

   // System reset is registered so every source acts on a clock edge.
   // The core restarts from address zero on the rising edge of sys_rst_n.
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sys_rst_q <= 1'b1;
      end else begin
         sys_rst_q <= rst_req;
      end
   end

   assign sys_rst_n = ~sys_rst_q;

   // ----------------------------------------------------------------
   // Wishbone slave
   // ----------------------------------------------------------------
   // Fixed one wait state: ack in the cycle after the request, writes commit
   // at the edge where ack is seen, unmapped indices read zero.
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign wr_cyc = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
   assign idx = wb_adr_i[9:2];
   assign wd = wb_dat_i[7:0];
   assign wr_pwr = wr_cyc & (idx == `RSC_IDX_PWR);
   assign wr_aux = wr_cyc & (idx == `RSC_IDX_AUX);
   assign wr_bod = wr_cyc & (idx == `RSC_IDX_BOD);
   assign wr_ist = wr_cyc & (idx == `RSC_IDX_IST);
   assign wr_imsk = wr_cyc & (idx == `RSC_IDX_IMSK);

   always @* begin
      rd_d = 8'h00;
      case (idx)
         `RSC_IDX_PWR: begin
            rd_d = pwr_q & `RSC_PWR_STORE;
            rd_d[`RSC_PWR_COLD] = cold_start_flag_q;
         end
         `RSC_IDX_AUX: begin
            rd_d = aux_q & `RSC_AUX_STORE;
            rd_d[`RSC_AUX_SOFT] = soft_reset_flag_q;
            rd_d[`RSC_AUX_PIN] = pin_reset_flag_q;
         end
         `RSC_IDX_BOD: begin
            rd_d = bod_q & `RSC_BOD_STORE;
            rd_d[`RSC_BOD_DETF] = brownout_detect_flag_q;
            rd_d[`RSC_BOD_RFLAG] = brownout_reset_flag_q;
            rd_d[`RSC_BOD_STAT] = brownout_status;
         end
         `RSC_IDX_IST: begin
            rd_d = {{(8-`RSC_IRQ_W){1'b0}}, ist};
         end
         `RSC_IDX_IMSK: begin
            rd_d = {{(8-`RSC_IRQ_W){1'b0}}, imsk};
         end
         default: begin
            rd_d = 8'h00;
         end
      endcase
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req & ~wb_ack_o;
         if (bus_req & ~wb_ack_o) begin
            wb_dat_o <= {24'h000000, rd_d};
         end
      end
   end

   // ----------------------------------------------------------------
   // Plain register storage
   // ----------------------------------------------------------------
   // Ordinary fields return to defaults on any system reset
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pwr_q <= `RSC_PWR_RST;
         aux_q <= `RSC_AUX_RST;
         bod_q <= `RSC_BOD_RST;
      end else if (sys_rst_q) begin
         pwr_q <= `RSC_PWR_RST;
         aux_q <= `RSC_AUX_RST;
         bod_q <= `RSC_BOD_RST;
      end else begin
         if (wr_pwr) begin
            pwr_q <= wd & `RSC_PWR_STORE;
         end
         if (wr_aux) begin
            aux_q <= wd & `RSC_AUX_STORE;
         end
         if (wr_bod) begin
            bod_q <= wd & `RSC_BOD_STORE;
         end
      end
   end

   // ----------------------------------------------------------------
   // Reset cause flags
   // ----------------------------------------------------------------
   // These flags ignore the system reset; only the power-on path or their
   // own source touches them, and a hardware set beats a software write.
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cold_start_flag_q <= 1'b1;
      end else if (!supply_good) begin
         cold_start_flag_q <= 1'b1;
      end else if (wr_pwr) begin
         cold_start_flag_q <= wd[`RSC_PWR_COLD];
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         brownout_reset_flag_q <= 1'b0;
      end else if (!supply_good) begin
         brownout_reset_flag_q <= 1'b0;
      end else if (bod_req) begin
         brownout_reset_flag_q <= 1'b1;
      end else if (wr_bod) begin
         brownout_reset_flag_q <= wd[`RSC_BOD_RFLAG];
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_reset_flag_q <= 1'b0;
      end else if (!supply_good) begin
         pin_reset_flag_q <= 1'b0;
      end else if (pin_req) begin
         pin_reset_flag_q <= 1'b1;
      end else if (wr_aux) begin
         pin_reset_flag_q <= wd[`RSC_AUX_PIN];
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         soft_reset_flag_q <= 1'b0;
      end else if (!supply_good) begin
         soft_reset_flag_q <= 1'b0;
      end else if (sw_reset_req) begin
         soft_reset_flag_q <= 1'b1;
      end else if (wr_aux) begin
         soft_reset_flag_q <= wd[`RSC_AUX_SOFT];
      end
   end

   // Detector flag clears on a system reset, but a below-level detector sets it and wins
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         brownout_detect_flag_q <= 1'b0;
      end else if (brownout_status) begin
         brownout_detect_flag_q <= 1'b1;
      end else if (sys_rst_q) begin
         brownout_detect_flag_q <= 1'b0;
      end else if (wr_bod) begin
         brownout_detect_flag_q <= wd[`RSC_BOD_DETF];
      end
   end

   // ----------------------------------------------------------------
   // Interrupt events
   // ----------------------------------------------------------------
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bod_below_q <= 1'b0;
      end else begin
         bod_below_q <= brownout_status;
      end
   end

   assign events = {pin_glitch, brownout_status & ~bod_below_q};

   rsc_event_reg u_evt (
      .clk(clk),
      .nrst(nrst),
      .clr(sys_rst_q),
      .ev(events),
      .wr_st(wr_ist),
      .wr_msk(wr_imsk),
      .wdata(wd[`RSC_IRQ_W-1:0]),
      .st_q(ist),
      .msk_q(imsk),
      .irq(irq)
   );

endmodule
